// file: hw/fos_defs.svh
// constants for the output fault supervisor
`ifndef FOS_DEFS_SVH
`define FOS_DEFS_SVH

`define FOS_WORD_W 16
`define FOS_BYTE_W 8
`define FOS_CMD_W 8
`define FOS_MODE_W 2
`define FOS_FIELD_W 3

`define FOS_CMD_UV_THR 8'h44
`define FOS_CMD_UV_RESP 8'h45
`define FOS_CMD_OC_THR 8'h46

`define FOS_MODE_DISABLE_RETRY 2'h2
`define FOS_RETRY_NONE 3'h0
`define FOS_RETRY_FOREVER 3'h7

`define FOS_UV_THR_RST 16'h0000
`define FOS_UV_RESP_RST 8'h80
`define FOS_OC_THR_RST 16'hffff

// retry step time and core clock rate
`define FOS_RETRY_STEP_MS 35
`define FOS_CLK_KHZ 40000
`define FOS_STEP_W 21
`define FOS_WAIT_W 24

`endif

// file: hw/fos_pkg.sv
// types shared by the output fault supervisor
package fos_pkg;
`include "fos_defs.svh"

  typedef enum logic [1:0] {
    ST_OFF,
    ST_ON,
    ST_WAIT,
    ST_LATCH
  } fos_state_t;

  typedef struct packed {
    logic [`FOS_MODE_W-1:0] mode;
    logic [`FOS_FIELD_W-1:0] retry;
    logic [`FOS_FIELD_W-1:0] rtime;
  } fos_resp_t;

  typedef struct packed {
    logic [`FOS_WORD_W-1:0] uv_thr;
    fos_resp_t resp;
    logic [`FOS_WORD_W-1:0] oc_thr;
  } fos_cfg_t;

  typedef struct packed {
    logic [`FOS_CMD_W-1:0] cmd;
    logic wr;
    logic rd;
    logic [`FOS_WORD_W-1:0] wdata;
  } fos_reg_req_t;

  typedef struct packed {
    logic [`FOS_WORD_W-1:0] rdata;
    logic ack;
    logic nack;
  } fos_reg_rsp_t;

  typedef struct packed {
    logic uv_fault;
    logic oc_fault;
    logic latched_off;
    logic alert_seen_low;
  } fos_status_t;
endpackage

// file: hw/fos_cmp.sv
// registered unsigned less-than comparator
`timescale 1ns/1ps
module fos_cmp #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // operands
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  // result
  output logic a_lt_b_q
);
  logic a_lt_b_d;

  always_comb begin
    a_lt_b_d = (a < b);
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      a_lt_b_q <= 1'b0;
    end else begin
      a_lt_b_q <= a_lt_b_d;
    end
  end
endmodule

// file: hw/fos_supervisor.sv
// output under-voltage / over-current fault supervisor with retry control
//
// Function
// - Hold a 16-bit under-voltage threshold and flag a fault when the measured output drops below it.
// - Drop power-good whenever the output is below that same under-voltage threshold.
// - Thresholds are read/write words and the response setting a read/write byte on the management port.
// - An under-voltage or over-current fault in the run state, whatever the response mode, pulls the alert line low and sets its status fault bit.
// - Under the disable-and-retry mode the output is switched off at once and the retry policy follows.
// - The three-bit retry setting gives how many restart attempts follow a fault shutdown.
// - A retry setting of zero means no restart; the output stays off until the fault is cleared.
// - A retry setting of all ones retries without limit until commanded off or another fault stops it.
// - Restarts are spaced by (retry time field + 1) times 35 ms, from 35 ms to 280 ms.
// - The over-current threshold applies to each phase on its own, so either phase can trip it.
`timescale 1ns/1ps
`include "fos_defs.svh"
module fos_supervisor #(
  parameter int unsigned RETRY_STEP_CYC = `FOS_RETRY_STEP_MS * `FOS_CLK_KHZ
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // management register port
  input wire fos_pkg::fos_reg_req_t reg_req,
  output fos_pkg::fos_reg_rsp_t reg_rsp_q,
  // measurements
  input wire logic [`FOS_WORD_W-1:0] vout_meas,
  input wire logic [`FOS_WORD_W-1:0] phase_a_cur,
  input wire logic [`FOS_WORD_W-1:0] phase_b_cur,
  // control
  input wire logic output_on_cmd,
  input wire logic fault_clear,
  input wire logic other_fault,
  // power stage and status
  output logic output_enable_q,
  output logic power_good_out_q,
  output fos_pkg::fos_status_t status_q,
  // open-drain alert
  input wire logic alert_line_n_in,
  output logic alert_line_n_out_q,
  output logic alert_line_n_oe_n_q
);
  import fos_pkg::*;

  localparam logic [`FOS_STEP_W-1:0] STEP_LAST = `FOS_STEP_W'(RETRY_STEP_CYC - 1);

  fos_cfg_t cfg_q, cfg_d;
  fos_reg_rsp_t rsp_d;
  fos_state_t state_q, state_d;
  logic [`FOS_STEP_W-1:0] step_q, step_d;
  logic [`FOS_FIELD_W-1:0] steps_q, steps_d;
  logic [`FOS_FIELD_W-1:0] rt_q, rt_d;
  logic [`FOS_FIELD_W-1:0] att_q, att_d;
  logic [`FOS_WAIT_W-1:0] wait_len_q, wait_len_d;
  fos_status_t status_d;
  logic out_en_d, pg_d, alert_oe_n_d;
  logic uv_low, oc_a, oc_b, fault_any, timer_done, dis_mode, may_retry;

  // one comparator per sensed quantity; each phase is checked separately
  fos_cmp #(.W(`FOS_WORD_W)) u_uv_cmp (
    .core_clk(core_clk), .rstn(rstn), .a(vout_meas), .b(cfg_q.uv_thr), .a_lt_b_q(uv_low));
  fos_cmp #(.W(`FOS_WORD_W)) u_oca_cmp (
    .core_clk(core_clk), .rstn(rstn), .a(cfg_q.oc_thr), .b(phase_a_cur), .a_lt_b_q(oc_a));
  fos_cmp #(.W(`FOS_WORD_W)) u_ocb_cmp (
    .core_clk(core_clk), .rstn(rstn), .a(cfg_q.oc_thr), .b(phase_b_cur), .a_lt_b_q(oc_b));

  // register file
  always_comb begin
    cfg_d = cfg_q;
    rsp_d = '0;
    if (reg_req.wr || reg_req.rd) begin
      case (reg_req.cmd)
        `FOS_CMD_UV_THR: begin
          if (reg_req.wr) cfg_d.uv_thr = reg_req.wdata;
          if (reg_req.rd) rsp_d.rdata = cfg_q.uv_thr;
          rsp_d.ack = 1'b1;
        end
        `FOS_CMD_UV_RESP: begin
          // byte transfer: only the low byte is stored, upper read bits are zero
          if (reg_req.wr) cfg_d.resp = reg_req.wdata[`FOS_BYTE_W-1:0];
          if (reg_req.rd) rsp_d.rdata = {{(`FOS_WORD_W-`FOS_BYTE_W){1'b0}}, cfg_q.resp};
          rsp_d.ack = 1'b1;
        end
        `FOS_CMD_OC_THR: begin
          if (reg_req.wr) cfg_d.oc_thr = reg_req.wdata;
          if (reg_req.rd) rsp_d.rdata = cfg_q.oc_thr;
          rsp_d.ack = 1'b1;
        end
        default: begin
          rsp_d.nack = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= {`FOS_UV_THR_RST, `FOS_UV_RESP_RST, `FOS_OC_THR_RST};
      reg_rsp_q <= '0;
    end else begin
      cfg_q <= cfg_d;
      reg_rsp_q <= rsp_d;
    end
  end

  // restart sequencer
  always_comb begin
    fault_any = uv_low || oc_a || oc_b;
    dis_mode = (cfg_q.resp.mode == `FOS_MODE_DISABLE_RETRY);
    may_retry = (cfg_q.resp.retry == `FOS_RETRY_FOREVER) || (att_q < cfg_q.resp.retry);
    timer_done = (step_q == STEP_LAST) && (steps_q == `FOS_RETRY_NONE);
    state_d = state_q;
    step_d = step_q;
    steps_d = steps_q;
    rt_d = rt_q;
    att_d = att_q;
    wait_len_d = (state_q == ST_WAIT) ? wait_len_q + `FOS_WAIT_W'(1) : '0;
    case (state_q)
      ST_OFF: begin
        att_d = '0;
        step_d = '0;
        if (output_on_cmd) state_d = ST_ON;
      end
      ST_ON: begin
        // a full step with no fault counts as a successful restart
        if (step_q == STEP_LAST) begin
          att_d = '0;
        end else begin
          step_d = step_q + `FOS_STEP_W'(1);
        end
        if (other_fault) begin
          state_d = ST_LATCH;
        end else if (fault_any && dis_mode) begin
          if (may_retry) begin
            state_d = ST_WAIT;
            step_d = '0;
            steps_d = cfg_q.resp.rtime;
            rt_d = cfg_q.resp.rtime;
          end else begin
            state_d = ST_LATCH;
          end
        end else if (!output_on_cmd) begin
          state_d = ST_OFF;
        end
      end
      ST_WAIT: begin
        if (other_fault) begin
          state_d = ST_LATCH;
        end else if (!output_on_cmd) begin
          state_d = ST_OFF;
        end else if (timer_done) begin
          state_d = ST_ON;
          step_d = '0;
          att_d = (att_q == `FOS_RETRY_FOREVER) ? att_q : att_q + `FOS_FIELD_W'(1);
        end else if (step_q == STEP_LAST) begin
          step_d = '0;
          steps_d = steps_q - `FOS_FIELD_W'(1);
        end else begin
          step_d = step_q + `FOS_STEP_W'(1);
        end
      end
      ST_LATCH: begin
        if (fault_clear) state_d = ST_OFF;
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
  end

  // status, alert and output drive; set wins over a clear in the same cycle
  always_comb begin
    status_d.uv_fault = (state_q == ST_ON && uv_low) || (status_q.uv_fault && !fault_clear);
    status_d.oc_fault = (state_q == ST_ON && (oc_a || oc_b)) || (status_q.oc_fault && !fault_clear);
    status_d.latched_off = (state_d == ST_LATCH);
    status_d.alert_seen_low = !alert_line_n_in;
    out_en_d = (state_d == ST_ON);
    pg_d = (state_d == ST_ON) && !uv_low;
    alert_oe_n_d = !(status_d.uv_fault || status_d.oc_fault);
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_OFF;
      step_q <= '0;
      steps_q <= '0;
      rt_q <= '0;
      att_q <= '0;
      wait_len_q <= '0;
      status_q <= '0;
      output_enable_q <= 1'b0;
      power_good_out_q <= 1'b0;
      alert_line_n_out_q <= 1'b0;
      alert_line_n_oe_n_q <= 1'b1;
    end else begin
      state_q <= state_d;
      step_q <= step_d;
      steps_q <= steps_d;
      rt_q <= rt_d;
      att_q <= att_d;
      wait_len_q <= wait_len_d;
      status_q <= status_d;
      output_enable_q <= out_en_d;
      power_good_out_q <= pg_d;
      // open drain: the pin level is only ever low, the enable decides
      alert_line_n_out_q <= 1'b0;
      alert_line_n_oe_n_q <= alert_oe_n_d;
    end
  end

  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_fault_on;
    state_q == ST_ON && fault_any && !other_fault;
  endsequence

  sequence s_dis_fault;
    s_fault_on ##0 dis_mode;
  endsequence

  AST_UV_FLAG: assert property ((state_q == ST_ON && uv_low) |=> status_q.uv_fault)
    else $error("under-voltage in run state did not set its status bit");
  AST_PG_DROP: assert property (uv_low |=> !power_good_out_q)
    else $error("power-good stayed high below the under-voltage threshold");
  AST_REG_ANSWER: assert property ((reg_req.wr || reg_req.rd) |=> (reg_rsp_q.ack != reg_rsp_q.nack))
    else $error("register access got no single answer");
  AST_ALERT_LOW: assert property (s_fault_on |=> !alert_line_n_oe_n_q ##0 !alert_line_n_out_q)
    else $error("fault did not pull the alert line low");
  AST_OFF_NOW: assert property (s_dis_fault |=> !output_enable_q && !power_good_out_q)
    else $error("disable-and-retry fault did not switch the output off at once");
  AST_RETRY_BOUND: assert property ((state_q == ST_ON && state_d == ST_WAIT) |->
      (cfg_q.resp.retry == `FOS_RETRY_FOREVER || att_q < cfg_q.resp.retry))
    else $error("restart scheduled beyond the retry setting");
  AST_NO_RETRY: assert property ((s_dis_fault ##0 cfg_q.resp.retry == `FOS_RETRY_NONE) |=>
      (state_q == ST_LATCH && !output_enable_q))
    else $error("retry setting zero did not latch the output off");
  AST_LATCH_HOLD: assert property ((state_q == ST_LATCH && !fault_clear) |=> !output_enable_q)
    else $error("latched-off output came back without a clear");
  AST_RETRY_FOREVER: assert property ((s_dis_fault ##0 cfg_q.resp.retry == `FOS_RETRY_FOREVER) |=>
      state_q == ST_WAIT)
    else $error("continuous retry did not schedule a restart");
  AST_RETRY_TIME: assert property ((state_q == ST_WAIT && timer_done) |->
      wait_len_q == `FOS_WAIT_W'((32'(rt_q) + 32'd1) * RETRY_STEP_CYC - 32'd1))
    else $error("restart delay differs from the programmed retry time");
  AST_OC_PHASE: assert property ((state_q == ST_ON && (oc_a || oc_b)) |=> status_q.oc_fault)
    else $error("single-phase over-current did not set its status bit");
  AST_EXHAUSTED: assert property ((s_dis_fault ##0 cfg_q.resp.retry != `FOS_RETRY_FOREVER
      ##0 att_q >= cfg_q.resp.retry) |=> state_q == ST_LATCH)
    else $error("used-up retry count did not keep the output off");
endmodule

// file: tb/fos_host.sv
// host model driving the supervisor's register port
`timescale 1ns/1ps
module fos_host (
  // clock
  input wire logic core_clk,
  // register port
  output fos_pkg::fos_reg_req_t reg_req,
  input wire fos_pkg::fos_reg_rsp_t reg_rsp_q
);
  import fos_pkg::*;
  initial reg_req = '0;
  // one strobe per access, answer taken on the next falling edge, one clock after it
  task automatic xfer(input logic [7:0] c, input logic w, input logic [15:0] d, output fos_reg_rsp_t rsp);
    @(negedge core_clk);
    reg_req = '{cmd: c, wr: w, rd: !w, wdata: d};
    @(negedge core_clk);
    reg_req = '0;
    rsp = reg_rsp_q;
  endtask
endmodule

// file: tb/tb_top.sv
// self-checking bench for the output fault supervisor
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_top;
  import fos_pkg::*;
  logic core_clk = 1'h0;
  logic rstn = 1'h0;
  fos_reg_req_t reg_req;
  fos_reg_rsp_t reg_rsp_q;
  fos_reg_rsp_t r;
  fos_status_t status_q;
  logic [15:0] vout_meas = 16'h0800;
  logic [15:0] phase_a_cur = 16'h0000;
  logic [15:0] phase_b_cur = 16'h0000;
  logic output_on_cmd = 1'h0;
  logic fault_clear = 1'h0;
  logic other_fault = 1'h0;
  logic output_enable_q, power_good_out_q, alert_line_n_out_q, alert_line_n_oe_n_q;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  int n;
  // the wire has a pull-up, so released means high
  wire alert_line_n = alert_line_n_oe_n_q ? 1'b1 : alert_line_n_out_q;

  always #12.5 core_clk = ~core_clk;

  fos_supervisor #(.RETRY_STEP_CYC(8)) i_fos_supervisor (.core_clk(core_clk), .rstn(rstn), .reg_req(reg_req),
    .reg_rsp_q(reg_rsp_q), .vout_meas(vout_meas), .phase_a_cur(phase_a_cur), .phase_b_cur(phase_b_cur),
    .output_on_cmd(output_on_cmd), .fault_clear(fault_clear), .other_fault(other_fault),
    .output_enable_q(output_enable_q), .power_good_out_q(power_good_out_q), .status_q(status_q),
    .alert_line_n_in(alert_line_n), .alert_line_n_out_q(alert_line_n_out_q),
    .alert_line_n_oe_n_q(alert_line_n_oe_n_q));

  fos_host i_fos_host (.core_clk(core_clk), .reg_req(reg_req), .reg_rsp_q(reg_rsp_q));

  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    i_fos_host.xfer(c, 1'b0, 16'h0000, r);
    `CHK("rd ack", 1'b1, r.ack)
    `CHK("rdata", e, r.rdata)
  endtask

  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    i_fos_host.xfer(c, 1'b1, d, r);
    `CHK("ack", 1'b1, r.ack)
  endtask

  // waits for the output enable to reach v, giving up after lim cycles
  task automatic wait_en(input logic v, input int lim);
    n = 0;
    while (output_enable_q !== v && n < lim) begin
      @(negedge core_clk);
      n++;
    end
  endtask

  task automatic clear_fault;
    @(negedge core_clk) fault_clear = 1'h1;
    @(negedge core_clk) fault_clear = 1'h0;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      report_and_stop();
    end
  end

  initial begin
    #75 rstn = 1'h1;
    rd(8'h44, 16'h0000);
    rd(8'h45, 16'h0080);
    rd(8'h46, 16'hffff);
    wr(8'h44, 16'h0400);
    rd(8'h44, 16'h0400);
    wr(8'h45, 16'h1289);
    rd(8'h45, 16'h0089);
    i_fos_host.xfer(8'h47, 1'b0, 16'h0000, r);
    `CHK("nack", 1'b1, r.nack)
    $display("register test done");
    `CHK("alert idle", 1'b0, status_q.alert_seen_low)
    output_on_cmd = 1'h1;
    wait_en(1'b1, 10);
    repeat (3) @(negedge core_clk);
    `CHK("pg on", 1'b1, power_good_out_q)
    // mode disable-and-retry, one retry, two steps of delay
    vout_meas = 16'h03ff;
    wait_en(1'b0, 5);
    `CHK("off delay", 2, n)
    `CHK("pg off", 1'b0, power_good_out_q)
    `CHK("uv bit", 1'b1, status_q.uv_fault)
    `CHK("alert", 1'b0, alert_line_n)
    vout_meas = 16'h0800;
    wait_en(1'b1, 40);
    `CHK("retry delay", 16, n)
    vout_meas = 16'h03ff;
    wait_en(1'b0, 5);
    vout_meas = 16'h0800;
    wait_en(1'b1, 40);
    `CHK("retries spent", 1'b0, output_enable_q)
    `CHK("latched", 1'b1, status_q.latched_off)
    clear_fault();
    wait_en(1'b1, 10);
    `CHK("restart after clear", 1'b1, output_enable_q)
    $display("retry test done");
    wr(8'h45, 16'h0080);
    vout_meas = 16'h03ff;
    wait_en(1'b0, 5);
    vout_meas = 16'h0800;
    wait_en(1'b1, 40);
    `CHK("no retry", 1'b0, output_enable_q)
    clear_fault();
    wait_en(1'b1, 10);
    `CHK("on after clear", 1'b1, output_enable_q)
    $display("no retry test done");
    wr(8'h45, 16'h00b8);
    vout_meas = 16'h03ff;
    repeat (3) begin
      wait_en(1'b0, 5);
      wait_en(1'b1, 20);
      `CHK("endless retry", 1'b1, output_enable_q)
    end
    vout_meas = 16'h0800;
    clear_fault();
    $display("endless retry test done");
    wr(8'h45, 16'h0000);
    wr(8'h46, 16'h0100);
    clear_fault();
    phase_a_cur = 16'h0100;
    repeat (4) @(negedge core_clk);
    `CHK("oc at limit", 1'b0, status_q.oc_fault)
    phase_b_cur = 16'h0101;
    repeat (4) @(negedge core_clk);
    `CHK("oc bit", 1'b1, status_q.oc_fault)
    `CHK("alert oc", 1'b0, alert_line_n)
    `CHK("still on", 1'b1, output_enable_q)
    `CHK("alert seen", 1'b1, status_q.alert_seen_low)
    // a foreign fault overrides the running state and latches the output off
    other_fault = 1'h1;
    @(negedge core_clk) other_fault = 1'h0;
    `CHK("other fault off", 1'b0, output_enable_q)
    `CHK("other fault latch", 1'b1, status_q.latched_off)
    wait_en(1'b1, 10);
    `CHK("latch holds", 1'b0, output_enable_q)
    $display("over-current test done");
    report_and_stop();
  end
endmodule
